// [core/boundary_scan_test_port.v]
// Purpose: boundary-scan test access port with programming instructions
// Assumes: tck, tms, tdi, trst-free; tck is sampled and its edges found on clk
// Notes: programming words leave through a FIFO; a word that finds it full waits and is lost if the next word finishes first
// Operation
// R1: Sample/preload captures live pin values into boundary register.
// R2: Sample/preload update loads pattern into update stage.
// R3: External test drives update stage to pins, captures input pins.
// R4: Bypass routes TDI to TDO through one stage.
// R5: Identification instruction puts identification register between TDI and TDO.
// R6: Identification is version, part number, maker field, fixed bit.
// R7: Identification least significant bit always reads one.
// R8: User-signature instruction shifts the signature register out.
// R9: User signature register is sixteen bits.
// R10: Instruction register is ten bits long.
// R11: Boundary register length set by density, 504 to 648.
// R12: Unused scan port pins serve as ordinary user pins.
// R13: Programming instructions accepted through the same port.
// R14: Security bit set blocks readback of configuration.
// R15: Security bit clears only by full erase; srst also clears it here.
// R16: User pins tri-stated while programming is in progress.
// R17: Sixteen-state controller; sample rising, TDO changes falling.
// R18: All-ones and unsupported opcodes select bypass.
`timescale 1ns/1ps
`include "scan_port_consts.vh"
module boundary_scan_test_port #(
  parameter BSR_LEN = `BSR_LEN,
  parameter HAS_IDCODE = 1,
  parameter HAS_USIG = 1,
  parameter [3:0] ID_VERSION = `ID_VERSION,
  parameter [15:0] ID_PART = `ID_PART,
  parameter [10:0] ID_MAKER = `ID_MAKER,
  parameter CELLS = BSR_LEN / 3
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Scan pins
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe,
  // Port use select and user-pin alternative
  input wire scan_enable,
  output reg [3:0] scan_pins_user,
  input wire [3:0] user_scan_pin_in,
  // Core side of user pins
  input wire [CELLS-1:0] core_out,
  input wire [CELLS-1:0] core_oe,
  output reg [CELLS-1:0] core_in,
  // Device pins
  input wire [CELLS-1:0] pin_in,
  output reg [CELLS-1:0] pin_out,
  output reg [CELLS-1:0] pin_oe,
  // Configuration memory
  input wire [15:0] user_signature,
  input wire [15:0] nvm_read_data,
  output reg [15:0] nvm_word,
  output reg nvm_word_valid,
  input wire nvm_ready,
  output reg nvm_erase,
  output reg security_bit,
  output reg in_system_programming
);
  reg [2:0] tck_s;
  reg [1:0] tms_s;
  reg [1:0] tdi_s;
  reg [1:0] en_s;
  reg [3:0] user_s1;
  reg [3:0] user_s2;
  reg [CELLS-1:0] pin_s1;
  reg [CELLS-1:0] pin_s2;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [`IR_LEN-1:0] ir_shift;
  reg [`IR_LEN-1:0] ir;
  reg [BSR_LEN-1:0] bsr;
  reg [BSR_LEN-1:0] bsr_upd;
  reg [31:0] id_shift;
  reg [15:0] sig_shift;
  reg [15:0] isp_shift;
  reg [3:0] isp_cnt;
  reg bypass_bit;
  reg tdo_next;
  reg fifo_valid;
  reg [15:0] fifo_data;
  wire fifo_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out;
  wire rise = tck_s[1] & ~tck_s[2];
  wire fall = ~tck_s[1] & tck_s[2];
  wire tms_i = tms_s[1];
  wire tdi_i = tdi_s[1];
  // R18 unknown to bypass
  wire op_extest = (ir == `OP_EXTEST);
  wire op_sample = (ir == `OP_SAMPLE);
  wire op_id = (ir == `OP_IDCODE) && (HAS_IDCODE != 0);
  wire op_sig = (ir == `OP_USIG) && (HAS_USIG != 0);
  wire op_prog = (ir == `OP_ISP_PROGRAM);
  wire op_read = (ir == `OP_ISP_READ);
  wire op_bypass = !(op_extest | op_sample | op_id | op_sig | op_prog | op_read);
  wire [31:0] id_value = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  // Boundary cells in order: input capture, output data, output enable
  reg [BSR_LEN-1:0] cap_vec;
  integer i;
  integer j;
  always @* begin
    cap_vec = {BSR_LEN{1'b0}};
    for (i = 0; i < CELLS; i = i + 1) begin
      cap_vec[3*i] = pin_s2[i];
      cap_vec[3*i+1] = op_extest ? bsr_upd[3*i+1] : core_out[i];
      cap_vec[3*i+2] = op_extest ? bsr_upd[3*i+2] : core_oe[i];
    end
  end
  // R17 controller
  always @* begin
    case (state)
      `ST_RESET: next_state = tms_i ? `ST_RESET : `ST_IDLE;
      `ST_IDLE: next_state = tms_i ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_DR: next_state = tms_i ? `ST_SEL_IR : `ST_CAP_DR;
      `ST_CAP_DR: next_state = tms_i ? `ST_EX1_DR : `ST_SH_DR;
      `ST_SH_DR: next_state = tms_i ? `ST_EX1_DR : `ST_SH_DR;
      `ST_EX1_DR: next_state = tms_i ? `ST_UPD_DR : `ST_PAU_DR;
      `ST_PAU_DR: next_state = tms_i ? `ST_EX2_DR : `ST_PAU_DR;
      `ST_EX2_DR: next_state = tms_i ? `ST_UPD_DR : `ST_SH_DR;
      `ST_UPD_DR: next_state = tms_i ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_IR: next_state = tms_i ? `ST_RESET : `ST_CAP_IR;
      `ST_CAP_IR: next_state = tms_i ? `ST_EX1_IR : `ST_SH_IR;
      `ST_SH_IR: next_state = tms_i ? `ST_EX1_IR : `ST_SH_IR;
      `ST_EX1_IR: next_state = tms_i ? `ST_UPD_IR : `ST_PAU_IR;
      `ST_PAU_IR: next_state = tms_i ? `ST_EX2_IR : `ST_PAU_IR;
      `ST_EX2_IR: next_state = tms_i ? `ST_UPD_IR : `ST_SH_IR;
      `ST_UPD_IR: next_state = tms_i ? `ST_SEL_DR : `ST_IDLE;
      default: next_state = `ST_RESET;
    endcase
  end
  // R5 serial output select
  always @* begin
    if (state == `ST_SH_IR)
      tdo_next = ir_shift[0];
    else if (op_extest | op_sample)
      tdo_next = bsr[0];
    else if (op_id)
      tdo_next = id_shift[0];
    else if (op_sig)
      tdo_next = sig_shift[0];
    else if (op_read)
      tdo_next = isp_shift[0];
    else
      tdo_next = bypass_bit;
  end
  // The host owns tck, so a detected edge is never skipped;
  // a finished word that meets a full FIFO replaces the pending one
  always @(posedge clk) begin
    if (srst) begin
      tck_s <= 3'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h0;
      en_s <= 2'h0;
      pin_s1 <= {CELLS{1'b0}};
      pin_s2 <= {CELLS{1'b0}};
      state <= `ST_RESET;
      ir_shift <= {`IR_LEN{1'b0}};
      ir <= `OP_BYPASS;
      bsr <= {BSR_LEN{1'b0}};
      bsr_upd <= {BSR_LEN{1'b0}};
      id_shift <= 32'h0;
      sig_shift <= 16'h0;
      isp_shift <= 16'h0;
      isp_cnt <= 4'h0;
      bypass_bit <= 1'b0;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      fifo_valid <= 1'b0;
      fifo_data <= 16'h0;
      nvm_erase <= 1'b0;
      security_bit <= 1'b0;
      in_system_programming <= 1'b0;
    end else begin
      tck_s <= {tck_s[1:0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
      en_s <= {en_s[0], scan_enable};
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      nvm_erase <= 1'b0;
      if (fifo_valid && fifo_ready)
        fifo_valid <= 1'b0;
      if (rise && en_s[1]) begin
        state <= next_state;
        case (state)
          `ST_RESET: begin
            ir <= `OP_BYPASS;
            in_system_programming <= 1'b0;
          end
          // R10 ten-bit scan
          `ST_CAP_IR: ir_shift <= `IR_CAPTURE;
          `ST_SH_IR: ir_shift <= {tdi_i, ir_shift[`IR_LEN-1:1]};
          `ST_UPD_IR: begin
            ir <= ir_shift;
            // R13 programming opcodes
            if (ir_shift == `OP_ISP_ENABLE)
              in_system_programming <= 1'b1;
            if (ir_shift == `OP_ISP_DISABLE)
              in_system_programming <= 1'b0;
            if (ir_shift == `OP_ISP_SECURE && in_system_programming)
              security_bit <= 1'b1;
            // R15 erase clears security
            if (ir_shift == `OP_ISP_ERASE && in_system_programming) begin
              security_bit <= 1'b0;
              nvm_erase <= 1'b1;
            end
          end
          `ST_CAP_DR: begin
            // R1 R3 pin capture
            bsr <= cap_vec;
            // R6 R7 identification
            id_shift <= id_value;
            // R8 R9 signature
            sig_shift <= user_signature;
            // R14 readback blocked
            isp_shift <= security_bit ? 16'h0 : nvm_read_data;
            isp_cnt <= 4'h0;
            bypass_bit <= 1'b0;
          end
          `ST_SH_DR: begin
            // R11 boundary length
            if (op_extest | op_sample)
              bsr <= {tdi_i, bsr[BSR_LEN-1:1]};
            if (op_id)
              id_shift <= {tdi_i, id_shift[31:1]};
            if (op_sig)
              sig_shift <= {tdi_i, sig_shift[15:1]};
            if (op_prog | op_read) begin
              isp_shift <= {tdi_i, isp_shift[15:1]};
              isp_cnt <= isp_cnt + 1'b1;
              if (op_prog && in_system_programming && isp_cnt == 4'hF) begin
                fifo_valid <= 1'b1;
                fifo_data <= {tdi_i, isp_shift[15:1]};
              end
            end
            // R4 single stage
            if (op_bypass)
              bypass_bit <= tdi_i;
          end
          // R2 update stage
          `ST_UPD_DR: begin
            if (op_extest | op_sample)
              bsr_upd <= bsr;
          end
          default: begin
          end
        endcase
      end
      // R17 output on falling edge
      if (fall && en_s[1]) begin
        tdo <= tdo_next;
        tdo_oe <= (state == `ST_SH_DR) || (state == `ST_SH_IR);
      end
      if (!en_s[1])
        tdo_oe <= 1'b0;
    end
  end
  // Pin drive: test pattern, tri-state while programming, or core
  always @(posedge clk) begin
    if (srst) begin
      pin_out <= {CELLS{1'b0}};
      pin_oe <= {CELLS{1'b0}};
      core_in <= {CELLS{1'b0}};
      scan_pins_user <= 4'h0;
      user_s1 <= 4'h0;
      user_s2 <= 4'h0;
      nvm_word <= 16'h0;
      nvm_word_valid <= 1'b0;
    end else begin
      core_in <= pin_s2;
      // R12 user pins
      user_s1 <= user_scan_pin_in;
      user_s2 <= user_s1;
      scan_pins_user <= en_s[1] ? 4'h0 : user_s2;
      nvm_word <= fifo_out;
      nvm_word_valid <= fifo_out_valid && nvm_ready;
      for (j = 0; j < CELLS; j = j + 1) begin
        // R16 tri-state
        if (in_system_programming) begin
          pin_out[j] <= 1'b0;
          pin_oe[j] <= 1'b0;
        // R3 drive pattern
        end else if (op_extest) begin
          pin_out[j] <= bsr_upd[3*j+1];
          pin_oe[j] <= bsr_upd[3*j+2];
        end else begin
          pin_out[j] <= core_out[j];
          pin_oe[j] <= core_oe[j];
        end
      end
    end
  end
  stream_fifo #(
    .WIDTH(16),
    .DEPTH(4),
    .AW(2)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_data),
    .out_valid(fifo_out_valid),
    .out_ready(nvm_ready),
    .out_data(fifo_out)
  );
endmodule

// [core/scan_port_consts.vh]
// Purpose: constants for the boundary-scan test port
// Assumes: included by bare name
// Notes: opcodes are ten bits; all-ones is bypass
`ifndef SCAN_PORT_CONSTS_VH
`define SCAN_PORT_CONSTS_VH
`define IR_LEN 10
`define BSR_LEN 504
`define IDREG_LEN 32
`define USIG_LEN 16
`define OP_EXTEST 10'h000
`define OP_SAMPLE 10'h055
`define OP_IDCODE 10'h059
`define OP_USIG 10'h079
`define OP_ISP_ENABLE 10'h2CC
`define OP_ISP_PROGRAM 10'h2F4
`define OP_ISP_ERASE 10'h2F2
`define OP_ISP_READ 10'h205
`define OP_ISP_SECURE 10'h2F9
`define OP_ISP_DISABLE 10'h201
`define OP_BYPASS 10'h3FF
`define IR_CAPTURE 10'h001
`define ISP_DATA_LEN 16
`define ID_VERSION 4'h1
`define ID_PART 16'h5A5A
`define ID_MAKER 11'h2AA
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SH_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PAU_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'hA
`define ST_SH_IR 4'hB
`define ST_EX1_IR 4'hC
`define ST_PAU_IR 4'hD
`define ST_EX2_IR 4'hE
`define ST_UPD_IR 4'hF
`endif

// [core/stream_fifo.v]
// Purpose: small valid/ready FIFO
// Assumes: single clock, synchronous active-high reset
// Notes: depth is a power of two
`timescale 1ns/1ps
module stream_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always @(posedge clk) begin
    if (srst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// [tb/scan_host.sv]
// Purpose: scan host driving tck, tms and tdi
// Assumes: 80 ns tck, stopped low between frames
// Notes: d holds bits to send, q bits seen, LSB first
`timescale 1ns/1ps
module scan_host (
  // Scan pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input logic tdo
);
  logic [0:511] d;
  logic [0:511] q;
  logic [9:0] opr;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task tick(input logic m, input logic i, output logic o);
    #20 tms = m;
    tdi = i;
    #20 tck = 1'b1;
    #20 o = tdo;
    #20 tck = 1'b0;
  endtask
  // Walks the tms path; tdi toggles as it carries nothing
  task move(input logic [7:0] p, input int n);
    logic o;
    for (int k = 0; k < n; k++) tick(p[k], ~tdi, o);
  endtask
  task scan(input logic sel, input int n);
    logic o;
    move(sel ? 8'h03 : 8'h01, sel ? 4 : 3);
    for (int k = 0; k < n; k++) begin
      tick(k == n - 1, sel ? opr[k] : d[k], o);
      q[k] = o;
    end
    move(8'h01, 2);
  endtask
  task ir(input logic [9:0] op);
    opr = op;
    scan(1'b1, 10);
  endtask
endmodule

// [tb/scan_port_checker.sv]
// Purpose: port assertions for the scan port
// Assumes: bound into boundary_scan_test_port
// Notes: scan pins reach the logic 2 to 4 clocks late
`timescale 1ns/1ps
module scan_port_checker #(
  parameter CELLS = 168
) (
  // Clock and reset
  input logic clk,
  input logic srst,
  // Watched ports
  input logic tck,
  input logic tdo,
  input logic scan_enable,
  input logic [3:0] scan_pins_user,
  input logic [3:0] user_scan_pin_in,
  input logic [CELLS-1:0] pin_oe,
  input logic nvm_erase,
  input logic security_bit,
  input logic in_system_programming
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_clears_isp: assert property (disable iff (1'b0) srst |=> !in_system_programming)
    else $error("programming mode left on by reset");
  a_tdo_after_fall: assert property ($changed(tdo) |-> !$past(tck, 2))
    else $error("tdo moved outside low tck");
  a_pins_zero_scan: assert property (scan_enable [*5] |-> scan_pins_user == 4'h0)
    else $error("user pins active while scanning");
  a_pins_copy_user: assert property ((!scan_enable && $stable(user_scan_pin_in)) [*5]
    |-> scan_pins_user == user_scan_pin_in)
    else $error("user pins not passed through");
  a_isp_pins_off: assert property (in_system_programming [*2] |-> pin_oe == '0)
    else $error("pins driven during programming");
  a_erase_one_cycle: assert property (nvm_erase |=> !nvm_erase)
    else $error("erase pulse too long");
  a_secure_clear_erase: assert property ($fell(security_bit)
    |-> nvm_erase || $past(nvm_erase))
    else $error("security cleared without erase");
  a_secure_needs_isp: assert property ($rose(security_bit) |-> in_system_programming)
    else $error("security set outside programming");
  c_isp: cover property ($rose(in_system_programming));
  c_secure: cover property ($rose(security_bit));
  c_erase: cover property (nvm_erase);
endmodule
bind boundary_scan_test_port scan_port_checker #(.CELLS(CELLS)) u_checker (
  .clk(clk), .srst(srst), .tck(tck), .tdo(tdo), .scan_enable(scan_enable),
  .scan_pins_user(scan_pins_user), .user_scan_pin_in(user_scan_pin_in), .pin_oe(pin_oe),
  .nvm_erase(nvm_erase), .security_bit(security_bit),
  .in_system_programming(in_system_programming));

// [tb/testbench.sv]
// Purpose: self-checking bench for the scan port
// Assumes: cell 3i input, 3i+1 output, 3i+2 enable
// Notes: every result compared with values built here
`timescale 1ns/1ps
`include "scan_port_consts.vh"
module testbench;
  localparam CELLS = 168;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, scan_enable, nvm_ready, nvm_word_valid;
  logic nvm_erase, security_bit, in_system_programming, saw_erase;
  logic [3:0] scan_pins_user, user_scan_pin_in;
  logic [CELLS-1:0] core_out, core_oe, core_in, pin_in, pin_out, pin_oe;
  logic [15:0] user_signature, nvm_read_data, nvm_word;
  logic [31:0] seed = 32'h43B6C6D1;
  logic [191:0] v;
  logic [9:0] ops[3] = '{`OP_BYPASS, 10'h123, 10'h2AB};
  logic [15:0] got[$];
  int bad_count = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  scan_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  boundary_scan_test_port u_dut (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .scan_enable(scan_enable), .scan_pins_user(scan_pins_user),
    .user_scan_pin_in(user_scan_pin_in), .core_out(core_out), .core_oe(core_oe),
    .core_in(core_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .user_signature(user_signature), .nvm_read_data(nvm_read_data), .nvm_word(nvm_word),
    .nvm_word_valid(nvm_word_valid), .nvm_ready(nvm_ready), .nvm_erase(nvm_erase),
    .security_bit(security_bit), .in_system_programming(in_system_programming));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [191:0] wide();
    return {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
  endfunction
  // Gathers every stride-th bit sent (src 1) or seen (src 0)
  function automatic logic [191:0] pick(input bit src, input int base, input int stride,
    input int n);
    logic [191:0] r;
    r = '0;
    for (int i = 0; i < n; i++) begin
      r[i] = src ? u_host.d[base + stride * i] : u_host.q[base + stride * i];
    end
    return r;
  endfunction
  task automatic fill(input int n);
    logic [31:0] r;
    for (int k = 0; k < n; k++) begin
      r = rnd();
      u_host.d[k] = r[0];
    end
  endtask
  task automatic chk(input string nm, input logic [191:0] x, input logic [191:0] y);
    n_checks++;
    if (y !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, x, y);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (nvm_word_valid === 1'b1) got.push_back(nvm_word);
    if (nvm_erase === 1'b1) saw_erase <= 1'b1;
  end
  initial begin
    #300000;
    bad_count++;
    close_out;
  end
  initial begin
    scan_enable = 1'b1;
    nvm_ready = 1'b0;
    saw_erase = 1'b0;
    user_scan_pin_in = 4'h0;
    v = wide();
    core_out = v[CELLS-1:0];
    v = wide();
    core_oe = v[CELLS-1:0];
    v = wide();
    pin_in = v[CELLS-1:0];
    v = wide();
    user_signature = v[15:0];
    nvm_read_data = v[31:16];
    repeat (10) @(posedge clk);
    #1 srst = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    u_host.move(8'h1F, 6);
    u_host.ir(`OP_IDCODE);
    chk("ir capture", `IR_CAPTURE, pick(0, 0, 1, 10));
    chk("tdo idle", 0, tdo_oe);
    u_host.scan(1'b0, 32);
    chk("idcode", {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1}, pick(0, 0, 1, 32));
    u_host.ir(`OP_USIG);
    u_host.scan(1'b0, 16);
    chk("signature", user_signature, pick(0, 0, 1, 16));
    u_host.ir(`OP_ISP_SECURE);
    chk("secure ignored", 0, security_bit);
    foreach (ops[j]) begin
      u_host.ir(ops[j]);
      fill(40);
      u_host.scan(1'b0, 40);
      chk("bypass", pick(1, 0, 1, 39) << 1, pick(0, 0, 1, 40));
    end
    u_host.ir(`OP_SAMPLE);
    chk("live pins", core_out, pin_out);
    fill(`BSR_LEN);
    u_host.scan(1'b0, `BSR_LEN);
    chk("sample in", pin_in, pick(0, 0, 3, CELLS));
    chk("core in", pin_in, core_in);
    chk("sample out", core_out, pick(0, 1, 3, CELLS));
    chk("sample oe", core_oe, pick(0, 2, 3, CELLS));
    u_host.ir(`OP_EXTEST);
    chk("preload out", pick(1, 1, 3, CELLS), pin_out);
    chk("preload oe", pick(1, 2, 3, CELLS), pin_oe);
    @(posedge clk);
    v = wide();
    #1 pin_in = v[CELLS-1:0];
    u_host.scan(1'b0, `BSR_LEN);
    chk("extest in", pin_in, pick(0, 0, 3, CELLS));
    chk("extest out", pick(1, 1, 3, CELLS), pick(0, 1, 3, CELLS));
    u_host.ir(`OP_ISP_ENABLE);
    chk("isp on", 1, in_system_programming);
    chk("pins off", 0, pin_oe);
    u_host.ir(`OP_ISP_PROGRAM);
    fill(72);
    u_host.scan(1'b0, 72);
    chk("words held", 0, got.size());
    @(posedge clk);
    #1 nvm_ready = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk("word count", 4, got.size());
    for (int w = 0; w < 4; w++) chk("word", pick(1, 16 * w, 1, 16), got[w]);
    u_host.ir(`OP_ISP_SECURE);
    chk("secure set", 1, security_bit);
    u_host.ir(`OP_ISP_READ);
    u_host.scan(1'b0, 16);
    chk("read blocked", 0, pick(0, 0, 1, 16));
    u_host.ir(`OP_ISP_ERASE);
    chk("erase pulse", 1, saw_erase);
    chk("secure clear", 0, security_bit);
    u_host.ir(`OP_ISP_READ);
    u_host.scan(1'b0, 16);
    chk("read open", nvm_read_data, pick(0, 0, 1, 16));
    u_host.ir(`OP_ISP_DISABLE);
    chk("isp off", 0, in_system_programming);
    @(posedge clk);
    v = wide();
    #1 scan_enable = 1'b0;
    user_scan_pin_in = v[3:0];
    repeat (6) @(posedge clk);
    chk("user pins", user_scan_pin_in, scan_pins_user);
    close_out;
  end
endmodule
